/* File: hdl/quad_supervisor_reset_watchdog.sv */
// digital core of a four-channel supply supervisor with watchdog
// assumes comparator levels arrive already digitised and asynchronous;
// monitor high means above the falling threshold, high-side high means
// above the rising threshold; delay selects and programmed counts are static
//
// Contract
// RULE1: four independent channels, each own reset output
// RULE2: channel 1 low on manual reset or undervoltage
// RULE3: channel 2 low while monitor under threshold
// RULE4: channel 3 low while monitor under threshold
// RULE5: channel 4 released only inside voltage window
// RULE6: release only after configured delay elapses
// RULE7: assert immediately, abandon running delay
// RULE8: delay applies per channel on each release
// RULE9: watchdog times out after 610 ms without kick
// RULE10: timeout output latched low until channel 1 reset
// RULE11: no timeout while channel 1 is asserted
// RULE12: processor kicks faster than watchdog period
// RULE13: delay choice: 300 ms, 20 ms, programmable
// RULE14: count starts at release, kick edge restarts
// RULE15: timeout cleared only by channel 1 assertion
// RULE16: pins synchronised, counters with constant terminals
`timescale 1ns/1ps

module quad_supervisor_reset_watchdog
   import supervisor_pkg::*;
#(
   parameter cnt_t LONG_CYC = `SUP_LONG_MS * 1000 * `SUP_CLK_MHZ,
   parameter cnt_t SHORT_CYC = `SUP_SHORT_MS * 1000 * `SUP_CLK_MHZ,
   parameter cnt_t WDT_CYC = `SUP_WDT_MS * 1000 * `SUP_CLK_MHZ
) (
   input wire logic mclk_in, // 100 MHz timebase
   input wire logic resetn_in, // synchronous reset, active low
   input wire logic manual_rst_in_n, // manual reset for channel 1, active low
   input wire logic watchdog_kick_in, // watchdog kick, either edge counts
   input wire logic ch1_monitor_in, // channel 1 above falling threshold
   input wire logic ch2_monitor_in, // channel 2 above falling threshold
   input wire logic ch3_monitor_in, // channel 3 above falling threshold
   input wire logic ch4_low_side_in, // channel 4 above falling threshold
   input wire logic ch4_high_side_in, // channel 4 above rising threshold
   input wire logic [3:0][1:0] delay_select_pin, // per-channel delay select
   input wire logic [3:0][31:0] prog_delay_in, // per-channel programmed cycles
   output logic ch1_rst_out_n, // channel 1 reset, active low
   output logic ch2_rst_out_n, // channel 2 reset, active low
   output logic ch3_rst_out_n, // channel 3 reset, active low
   output logic ch4_rst_out_n, // channel 4 reset, active low
   output logic watchdog_timeout_out_n // latched watchdog timeout, active low
);

   localparam top_st_t ST_RST = '{
      s1: '0, s2: '0, s3: '0, filt: '0,
      kick_prev: 1'b0, wd_cnt: '0, wdo_n: 1'b1
   };

   top_st_t st_r;
   top_st_t st_nxt;
   pins_t pins;
   logic [3:0] ok;
   logic [3:0] ch_rst_n;
   logic kick_edge;

   always_comb begin
      pins = '0;
      pins.prog = prog_delay_in;
      pins.sel = delay_select_pin;
      pins.mr_n = manual_rst_in_n;
      pins.kick = watchdog_kick_in;
      pins.mon1 = ch1_monitor_in;
      pins.mon2 = ch2_monitor_in;
      pins.mon3 = ch3_monitor_in;
      pins.mon4_low = ch4_low_side_in;
      pins.mon4_high = ch4_high_side_in;
   end

   // release conditions per channel
   assign ok[0] = st_r.filt.mr_n & st_r.filt.mon1; // RULE2
   assign ok[1] = st_r.filt.mon2; // RULE3
   assign ok[2] = st_r.filt.mon3; // RULE4
   assign ok[3] = st_r.filt.mon4_low & ~st_r.filt.mon4_high; // RULE5

   assign kick_edge = st_r.filt.kick ^ st_r.kick_prev;

   always_comb begin
      st_nxt = st_r;
      // three stages; a bit moves only once stages two and three agree
      st_nxt.s1 = pins; // RULE16
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));
      st_nxt.kick_prev = st_r.filt.kick;
      if (!ch_rst_n[0]) begin
         // channel 1 asserted: count held off, latch cleared
         st_nxt.wd_cnt = '0; // RULE11
         st_nxt.wdo_n = 1'b1; // RULE15
      end else if (!st_r.wdo_n) begin
         st_nxt.wd_cnt = '0; // RULE10
      end else if (kick_edge) begin
         st_nxt.wd_cnt = '0; // RULE14
      end else if (st_r.wd_cnt >= WDT_CYC - 32'h1) begin
         st_nxt.wdo_n = 1'b0; // RULE9
         st_nxt.wd_cnt = '0;
      end else begin
         st_nxt.wd_cnt = st_r.wd_cnt + 32'h1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // one instance per channel, each fully independent
   genvar g;
   generate
      for (g = 0; g < `SUP_CHANNELS; g = g + 1) begin : g_ch
         sv_channel #(
            .LONG_CYC(LONG_CYC),
            .SHORT_CYC(SHORT_CYC)
         ) u_ch (
            .mclk_in(mclk_in),
            .resetn_in(resetn_in),
            .ok_in(ok[g]), // RULE1
            .sel_in(st_r.filt.sel[g]),
            .prog_in(st_r.filt.prog[g]),
            .rst_out_n(ch_rst_n[g])
         );
      end
   endgenerate

   assign ch1_rst_out_n = ch_rst_n[0];
   assign ch2_rst_out_n = ch_rst_n[1];
   assign ch3_rst_out_n = ch_rst_n[2];
   assign ch4_rst_out_n = ch_rst_n[3];
   assign watchdog_timeout_out_n = st_r.wdo_n;

   sequence s_ch1_quiet;
      ch1_rst_out_n && watchdog_timeout_out_n && !kick_edge;
   endsequence

   sequence s_kick_seen;
      ch1_rst_out_n && watchdog_timeout_out_n && kick_edge;
   endsequence

   a_ch1_manual: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE2
      !st_r.filt.mr_n |=> !ch1_rst_out_n)
      else $error("manual reset did not hold channel 1");

   a_ch1_under: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE2
      !st_r.filt.mon1 |=> !ch1_rst_out_n)
      else $error("undervoltage did not hold channel 1");

   a_ch2_under: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE3
      !st_r.filt.mon2 |=> !ch2_rst_out_n)
      else $error("undervoltage did not hold channel 2");

   a_ch3_under: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE4
      !st_r.filt.mon3 |=> !ch3_rst_out_n)
      else $error("undervoltage did not hold channel 3");

   a_ch4_window: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE5
      (!st_r.filt.mon4_low || st_r.filt.mon4_high) |=> !ch4_rst_out_n)
      else $error("channel 4 released outside window");

   a_wdo_timeout: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE9
      $fell(watchdog_timeout_out_n) |-> $past(st_r.wd_cnt) == WDT_CYC - 32'h1)
      else $error("watchdog timed out at wrong count");

   a_wdo_quiet_count: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE9
      s_ch1_quiet ##0 (st_r.wd_cnt < WDT_CYC - 32'h1) |=> st_r.wd_cnt == $past(st_r.wd_cnt) + 32'h1)
      else $error("watchdog count did not advance");

   a_wdo_latched: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE10
      (!watchdog_timeout_out_n && ch1_rst_out_n) |=> !watchdog_timeout_out_n)
      else $error("timeout released without channel 1 reset");

   a_wdo_cleared: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE15
      !ch1_rst_out_n |=> watchdog_timeout_out_n && st_r.wd_cnt == '0)
      else $error("timeout not cleared by channel 1 reset");

   a_kick_restart: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE14
      s_kick_seen |=> st_r.wd_cnt == '0 && watchdog_timeout_out_n)
      else $error("kick edge did not restart watchdog");

   a_sync_agree: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE16
      $changed(st_r.filt) |-> $past(st_r.s2) == $past(st_r.s3)
         || $past(st_r.filt) != st_r.filt && (st_r.filt & ~($past(st_r.s2)
         ~^ $past(st_r.s3))) == ($past(st_r.filt) & ~($past(st_r.s2) ~^ $past(st_r.s3))))
      else $error("pin change taken before stages agreed");

endmodule

/* File: hdl/supervisor_map.svh */
// constants of the quad supervisor: timebase, delay and watchdog figures, select codes
// assumes a single free-running timebase; no bus-visible registers exist
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

`define SUP_CLK_MHZ 100
`define SUP_LONG_MS 300
`define SUP_SHORT_MS 20
`define SUP_WDT_MS 610
`define SUP_CNT_W 32
`define SUP_CHANNELS 4

// delay select codes, one pair of pins per channel
`define SUP_SEL_SHORT 2'h0
`define SUP_SEL_LONG 2'h1
`define SUP_SEL_PROG 2'h2
`define SUP_SEL_PROG_ALT 2'h3

// channel state codes, one-hot
`define SUP_ST_ASSERTED 3'h1
`define SUP_ST_DELAY 3'h2
`define SUP_ST_RELEASED 3'h4

`endif

/* File: hdl/supervisor_pkg.sv */
// types shared by the supervisor channel and the supervisor top
// assumes supervisor_map.svh is on the include path
`include "supervisor_map.svh"

package supervisor_pkg;

   typedef logic [`SUP_CNT_W-1:0] cnt_t;

   typedef enum logic [2:0] {
      CH_ASSERTED = `SUP_ST_ASSERTED,
      CH_DELAY = `SUP_ST_DELAY,
      CH_RELEASED = `SUP_ST_RELEASED
   } chan_state_t;

   typedef enum logic [1:0] {
      SEL_SHORT = `SUP_SEL_SHORT,
      SEL_LONG = `SUP_SEL_LONG,
      SEL_PROG = `SUP_SEL_PROG,
      SEL_PROG_ALT = `SUP_SEL_PROG_ALT
   } dly_sel_t;

   // every pin that arrives from outside the timebase
   typedef struct packed {
      logic [`SUP_CHANNELS-1:0][`SUP_CNT_W-1:0] prog;
      logic [`SUP_CHANNELS-1:0][1:0] sel;
      logic mr_n;
      logic kick;
      logic mon1;
      logic mon2;
      logic mon3;
      logic mon4_low;
      logic mon4_high;
   } pins_t;

   typedef struct packed {
      chan_state_t state;
      cnt_t cnt;
      cnt_t term;
      logic out_n;
   } chan_st_t;

   typedef struct packed {
      pins_t s1;
      pins_t s2;
      pins_t s3;
      pins_t filt;
      logic kick_prev;
      cnt_t wd_cnt;
      logic wdo_n;
   } top_st_t;

endpackage

/* File: hdl/sv_channel.sv */
// one supervisory channel: immediate assert, delayed release
// assumes ok_in, sel_in and prog_in are already synchronised to mclk_in
`timescale 1ns/1ps

module sv_channel
   import supervisor_pkg::*;
#(
   parameter cnt_t LONG_CYC = 32'h1,
   parameter cnt_t SHORT_CYC = 32'h1
) (
   input wire logic mclk_in, // timebase
   input wire logic resetn_in, // synchronous reset, active low
   input wire logic ok_in, // all release conditions hold
   input wire logic [1:0] sel_in, // delay select code
   input wire cnt_t prog_in, // programmable delay in cycles
   output logic rst_out_n // channel reset, active low
);

   localparam chan_st_t ST_RST = '{state: CH_ASSERTED, cnt: '0, term: 32'h1, out_n: 1'b0};

   chan_st_t st_r;
   chan_st_t st_nxt;
   cnt_t run_r;

   function automatic cnt_t pick_term(input logic [1:0] sel, input cnt_t prog);
      cnt_t t;
      unique case (dly_sel_t'(sel))
         SEL_SHORT: t = SHORT_CYC;
         SEL_LONG: t = LONG_CYC;
         SEL_PROG, SEL_PROG_ALT: t = prog;
      endcase
      // a zero count would wrap to the longest possible delay; one cycle is the floor
      if (t == '0) begin
         t = 32'h1;
      end
      return t;
   endfunction

   always_comb begin
      st_nxt = st_r;
      if (!ok_in) begin
         st_nxt.state = CH_ASSERTED; // RULE7
         st_nxt.cnt = '0;
         st_nxt.out_n = 1'b0;
      end else begin
         unique case (st_r.state)
            CH_ASSERTED: begin
               st_nxt.state = CH_DELAY; // RULE8
               st_nxt.cnt = '0;
               st_nxt.term = pick_term(sel_in, prog_in); // RULE13
            end
            CH_DELAY: begin
               if (st_r.cnt >= st_r.term - 32'h1) begin
                  st_nxt.state = CH_RELEASED; // RULE6
                  st_nxt.out_n = 1'b1;
               end else begin
                  st_nxt.cnt = st_r.cnt + 32'h1;
               end
            end
            CH_RELEASED: st_nxt.out_n = 1'b1;
            default: begin
               st_nxt.state = CH_ASSERTED;
               st_nxt.out_n = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rst_out_n = st_r.out_n;

   // helper: consecutive cycles with ok_in high, saturating
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || !ok_in) begin
         run_r <= '0;
      end else if (run_r != '1) begin
         run_r <= run_r + 32'h1;
      end
   end

   a_assert_at_once: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE7
      !ok_in |=> !rst_out_n)
      else $error("channel reset not asserted one cycle after fault");

   a_release_exact: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE6
      $rose(rst_out_n) |-> $past(run_r) == $past(st_r.term))
      else $error("channel released after wrong delay");

   a_delay_holds_low: assert property (@(posedge mclk_in) disable iff (!resetn_in) // RULE8
      st_r.state == CH_DELAY |-> !rst_out_n)
      else $error("channel released while delay runs");

endmodule

/* File: tb/cpu_partner.sv */
// processor model on the far side: takes channel 1 reset, kicks the watchdog
// assumes the bench timebase clocks it; it kicks only while enabled
`timescale 1ns/1ps
module cpu_partner (
   input wire logic mclk_in, // timebase
   input wire logic cpu_rst_in_n, // channel 1 reset into the processor
   input wire logic kick_en_in, // processor services the watchdog
   input wire logic [7:0] gap_in, // cycles between kick edges
   output logic kick_out // watchdog kick level
);
   logic [7:0] wait_r = 8'h00;
   logic kick_r = 1'b0;
   assign kick_out = kick_r;
   // a processor held in reset cannot run its service loop
   always @(posedge mclk_in) begin
      if (!cpu_rst_in_n || !kick_en_in) begin
         wait_r <= 8'h00;
      end else if (wait_r + 8'h01 >= gap_in) begin
         wait_r <= 8'h00;
         kick_r <= ~kick_r;
      end else begin
         wait_r <= wait_r + 8'h01;
      end
   end
endmodule

/* File: tb/quad_supervisor_reset_watchdog_bench.sv */
// bench for the quad supervisor: channel delays, window, watchdog
// assumes short counts on the top's parameters; the partner kicks the watchdog
`timescale 1ns/1ps
module quad_supervisor_reset_watchdog_bench;
   import supervisor_pkg::*;
   localparam cnt_t LC = 32'h28;
   localparam cnt_t SC = 32'hA;
   localparam cnt_t WC = 32'h3C;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic mr_n = 1'b1;
   logic [3:0] mon = 4'h0; // channel 1..3 monitors, channel 4 low side
   logic high_side = 1'b0;
   logic [3:0][1:0] sel = '0;
   logic [3:0][31:0] prog = '0;
   logic kick_en = 1'b0;
   logic [7:0] gap = 8'h10;
   wire kick;
   wire [4:0] obs; // timeout, then channel 4..1 resets
   integer bad_count = 0;
   integer check_count = 0;
   integer seed = 32'hB94E;
   integer n, a, r, i, c;

   initial forever #5 mclk_in = ~mclk_in;

   quad_supervisor_reset_watchdog #(.LONG_CYC(LC), .SHORT_CYC(SC), .WDT_CYC(WC)) dut_u (
      .mclk_in(mclk_in), .resetn_in(resetn_in), .manual_rst_in_n(mr_n),
      .watchdog_kick_in(kick), .ch1_monitor_in(mon[0]), .ch2_monitor_in(mon[1]),
      .ch3_monitor_in(mon[2]), .ch4_low_side_in(mon[3]), .ch4_high_side_in(high_side),
      .delay_select_pin(sel), .prog_delay_in(prog), .ch1_rst_out_n(obs[0]),
      .ch2_rst_out_n(obs[1]), .ch3_rst_out_n(obs[2]), .ch4_rst_out_n(obs[3]),
      .watchdog_timeout_out_n(obs[4]));

   cpu_partner part_u (.mclk_in(mclk_in), .cpu_rst_in_n(obs[0]), .kick_en_in(kick_en),
      .gap_in(gap), .kick_out(kick));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input integer k);
      repeat (k) @(posedge mclk_in);
      #1;
   endtask

   // counts edges until an output reaches a level; a used-up bound ends the run
   task automatic wait_for(input integer idx, input logic lvl, output integer cnt);
      cnt = 0;
      while (obs[idx] !== lvl && cnt < 300) begin
         tick(1);
         cnt = cnt + 1;
      end
      if (cnt >= 300) begin
         check(obs[idx], lvl);
         finish_test();
      end
   endtask

   task automatic drive(input integer ch, input logic v);
      @(posedge mclk_in);
      mon[ch] <= v;
      #1;
   endtask

   function automatic cnt_t term_of(input logic [1:0] s, input cnt_t p);
      if (s == 2'h0) return SC;
      if (s == 2'h1) return LC;
      return (p == 32'h0) ? 32'h1 : p;
   endfunction

   // release latency minus assert latency isolates the configured delay
   task automatic cycle(input integer ch, input logic [1:0] s, input cnt_t p);
      sel[ch] <= s;
      prog[ch] <= p;
      drive(ch, 1'b1);
      wait_for(ch, 1'b1, r);
      drive(ch, 1'b0);
      wait_for(ch, 1'b0, a);
      check(r - a, term_of(s, p));
      check(a >= 4 && a <= 5, 1'b1);
   endtask

   initial begin
      repeat (8) @(posedge mclk_in);
      #1;
      check(obs, 5'h10);
      @(posedge mclk_in);
      resetn_in <= 1'b1;
      gap <= 8'h05 + 8'($unsigned($random(seed)) % 20);
      kick_en <= 1'b1;
      tick(6);
      for (c = 0; c < 4; c = c + 1) begin
         for (i = 0; i < 4; i = i + 1) begin
            cycle(c, 2'(i), 32'($unsigned($random(seed)) % 16 + 1));
         end
      end
      cycle(1, 2'h2, 32'h0);
      $display("done: channel delays");
      // back to the short delay so the abandoned release has time to be seen
      sel[1] <= 2'h0;
      drive(1, 1'b1);
      tick(6);
      check(obs[1], 1'b0);
      drive(1, 1'b0);
      tick(2);
      drive(1, 1'b1);
      wait_for(1, 1'b1, r);
      check(r - a, SC);
      drive(1, 1'b0);
      wait_for(1, 1'b0, n);
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge mclk_in);
         mon[3] <= i[1];
         high_side <= i[0];
         tick(30);
         check(obs[3], i == 2);
      end
      drive(3, 1'b0);
      $display("done: window and abandon");
      kick_en <= 1'b0;
      drive(0, 1'b1);
      wait_for(0, 1'b1, r);
      @(posedge mclk_in);
      mr_n <= 1'b0;
      #1;
      wait_for(0, 1'b0, a);
      check(a >= 3 && a <= 5, 1'b1);
      tick(20);
      check(obs[0], 1'b0);
      @(posedge mclk_in);
      mr_n <= 1'b1;
      #1;
      wait_for(0, 1'b1, r);
      wait_for(4, 1'b0, n);
      check(n, WC);
      kick_en <= 1'b1;
      tick(150);
      check(obs[4], 1'b0);
      drive(0, 1'b0);
      wait_for(0, 1'b0, a);
      wait_for(4, 1'b1, n);
      check(n <= 1, 1'b1);
      kick_en <= 1'b0;
      tick(100);
      check(obs[4], 1'b1);
      gap <= 8'h03 + 8'($unsigned($random(seed)) % 38);
      kick_en <= 1'b1;
      drive(0, 1'b1);
      wait_for(0, 1'b1, r);
      tick(250);
      check(obs[4], 1'b1);
      $display("done: watchdog");
      finish_test();
   end
endmodule
